/* ccss_clkgen.sv */
// Purpose: cpu clock start and switch control with apb registers
// Assumes: oscillators are analog, reported back as pin levels
// Notes:   cpu and prescaler clocks leave as one-pclk tick enables
// Functional notes
// RULE1 - internal oscillator starts at reset release and runs at 240 kHz as the start clock.
// RULE2 - a strap fixes the internal oscillator stoppable or not; stop requests act only if stoppable.
// RULE3 - the prescaler divides whichever oscillator currently drives the cpu.
// RULE4 - any reset clears the cpu clock select bit so the internal clock drives the cpu.
// RULE5 - the cpu gets no clock until 17 internal ticks after reset release.
// RULE6 - both oscillators stay stopped while reset is asserted.
// RULE7 - software selects the high-speed clock only after the status register shows it stable.
// RULE8 - a read-only bit shows which source currently drives the cpu.
// RULE9 - software stops the internal oscillator only when stoppable and source flag is 1.
// RULE10 - software stops the high-speed oscillator only when source flag is 0.
// RULE11 - on stop release on the high-speed clock the cpu waits the selected stabilisation time.
// RULE12 - on stop release on the internal clock software checks stability before switching.
// RULE13 - with the rc oscillator software may switch without checking stability.
// RULE14 - the select field resets to 05h and only codes 1 to 5 are legal.
// RULE15 - status clears on reset, stop entry or high-speed stop, and sets bits in order.
`timescale 1ns/1ps
module ccss_clkgen
  import ccss_pkg::*;
(
  // clock, reset, enable
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  ce,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ccss_pkg::CCSS_AW-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // oscillator pins and straps
  input  wire logic                  int_osc_in,
  input  wire logic                  hs_osc_in,
  input  wire logic                  int_osc_stoppable,
  input  wire logic                  stop_mode,
  // clock control outputs
  output logic                       int_osc_en,
  output logic                       hs_osc_en,
  output logic                       cpu_clk_en,
  output logic                       presc_tick,
  output logic                       cpu_clock_source_flag
);
  import ccss_pkg::*;

  logic        int_rise;
  logic        hs_rise;
  logic        cpu_clock_select;
  logic        rstop_reg;
  logic        mstop_reg;
  logic [2:0]  stab_time_select_reg;
  logic [4:0]  stab_time_status_reg;
  logic [16:0] stab_cnt_reg;
  logic [4:0]  por_cnt_reg;
  logic        por_done;
  logic        strap_done_reg;
  logic        stoppable_reg;
  logic        stop_d_reg;
  logic        stab_wait_reg;
  logic [16:0] stab_limit;
  logic        stab_reached;
  logic        cpu_hold;
  logic        src_tick;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;

  ccss_sync u_int_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .d       (int_osc_in),
    .rise    (int_rise)
  );

  ccss_sync u_hs_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .d       (hs_osc_in),
    .rise    (hs_rise)
  );

  // apb decode, zero wait, read data caught at setup
  assign addr_ok = (paddr == CCSS_MCM_OFS)  || (paddr == CCSS_RCM_OFS)
                || (paddr == CCSS_MOC_OFS)  || (paddr == CCSS_STAB_TIME_SELECT_REG_OFS)
                || (paddr == CCSS_STAB_TIME_STATUS_REG_OFS);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign wr_en   = ce && psel && penable && pwrite;
  assign rd_en   = ce && psel && !penable && !pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= 32'h0000_0000;
      unique case (paddr)
        CCSS_MCM_OFS: begin
          prdata[CCSS_SEL_BIT] <= cpu_clock_select;
          prdata[CCSS_SRC_BIT] <= cpu_clock_source_flag; // see RULE8
        end
        CCSS_RCM_OFS:  prdata[CCSS_RSTOP_BIT] <= rstop_reg;
        CCSS_MOC_OFS:  prdata[CCSS_MSTOP_BIT] <= mstop_reg;
        CCSS_STAB_TIME_SELECT_REG_OFS: prdata[2:0] <= stab_time_select_reg;
        CCSS_STAB_TIME_STATUS_REG_OFS: prdata[4:0] <= stab_time_status_reg;
        default:       prdata <= 32'h0000_0000;
      endcase
    end
  end

  // control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_clock_select     <= 1'b0; // see RULE4
      rstop_reg            <= 1'b0;
      mstop_reg            <= 1'b0;
      stab_time_select_reg <= CCSS_STAB_TIME_SELECT_REG_RST; // see RULE14
    end else if (wr_en) begin
      if (paddr == CCSS_MCM_OFS) begin
        cpu_clock_select <= pwdata[CCSS_SEL_BIT];
      end
      if (paddr == CCSS_RCM_OFS) begin
        rstop_reg <= pwdata[CCSS_RSTOP_BIT];
      end
      if (paddr == CCSS_MOC_OFS) begin
        mstop_reg <= pwdata[CCSS_MSTOP_BIT];
      end
      // prohibited codes leave the field unchanged
      if ((paddr == CCSS_STAB_TIME_SELECT_REG_OFS) && (pwdata[2:0] >= CCSS_SEL11)
          && (pwdata[2:0] <= CCSS_SEL16)) begin
        stab_time_select_reg <= pwdata[2:0]; // see RULE14
      end
    end
  end

  // strap caught after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_done_reg <= 1'b0;
      stoppable_reg  <= 1'b0;
    end else if (ce && !strap_done_reg) begin
      strap_done_reg <= 1'b1;
      stoppable_reg  <= int_osc_stoppable; // see RULE2
    end
  end

  // oscillator enables, off during reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_osc_en <= 1'b0; // see RULE6
      hs_osc_en  <= 1'b0; // see RULE6
    end else if (ce) begin
      int_osc_en <= !(stoppable_reg && rstop_reg && strap_done_reg); // see RULE1
      hs_osc_en  <= !mstop_reg && !stop_mode;
    end
  end

  // 17 internal ticks before the cpu runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_cnt_reg <= 5'h00;
    end else if (ce && int_rise && !por_done) begin
      por_cnt_reg <= por_cnt_reg + 5'h01; // see RULE5
    end
  end
  assign por_done = (por_cnt_reg == CCSS_POR_TICKS);

  // source flag follows select on a tick of the new source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_clock_source_flag <= 1'b0;
    end else if (ce && (cpu_clock_select != cpu_clock_source_flag)) begin
      if (cpu_clock_select ? hs_rise : int_rise) begin
        cpu_clock_source_flag <= cpu_clock_select; // see RULE8
      end
    end
  end

  // stabilisation counter and stop tracking
  always_comb begin
    unique case (stab_time_select_reg)
      CCSS_SEL11: stab_limit = CCSS_T11;
      CCSS_SEL13: stab_limit = CCSS_T13;
      CCSS_SEL14: stab_limit = CCSS_T14;
      CCSS_SEL15: stab_limit = CCSS_T15;
      default:    stab_limit = CCSS_T16;
    endcase
  end
  assign stab_reached = (stab_cnt_reg >= stab_limit);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stab_cnt_reg  <= 17'h00000;
      stop_d_reg    <= 1'b0;
      stab_wait_reg <= 1'b0;
    end else if (ce) begin
      stop_d_reg <= stop_mode;
      if (stop_mode || mstop_reg) begin
        stab_cnt_reg <= 17'h00000; // see RULE15
      end else if (hs_rise && (stab_wait_reg ? !stab_reached
                                 : (stab_cnt_reg < CCSS_T16))) begin
        stab_cnt_reg <= stab_cnt_reg + 17'h00001;
      end
      if (stop_d_reg && !stop_mode) begin
        stab_wait_reg <= 1'b1; // count only to the selected time
      end else if (stop_mode) begin
        stab_wait_reg <= 1'b0;
      end
    end
  end

  // thermometer status, shortest threshold first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stab_time_status_reg <= CCSS_STAB_TIME_STATUS_REG_RST; // see RULE15
    end else if (ce) begin
      if (stop_mode || mstop_reg) begin
        stab_time_status_reg <= CCSS_STAB_TIME_STATUS_REG_RST; // see RULE15
      end else begin
        stab_time_status_reg <= {stab_cnt_reg >= CCSS_T11,
                                 stab_cnt_reg >= CCSS_T13,
                                 stab_cnt_reg >= CCSS_T14,
                                 stab_cnt_reg >= CCSS_T15,
                                 stab_cnt_reg >= CCSS_T16};
      end
    end
  end

  // cpu and prescaler ticks
  assign cpu_hold   = !por_done || stop_mode
                   || (stab_wait_reg && cpu_clock_source_flag
                       && !stab_reached); // see RULE11
  assign src_tick   = cpu_clock_source_flag ? hs_rise : int_rise; // see RULE3
  assign presc_tick = src_tick && !stop_mode && por_done;
  assign cpu_clk_en = src_tick && !cpu_hold; // see RULE5

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_stop_release;
    stop_d_reg && !stop_mode && ce;
  endsequence
  sequence s_hs_wait;
    stab_wait_reg && cpu_clock_source_flag && !stab_reached;
  endsequence

  property p_por_hold;
    (por_cnt_reg < CCSS_POR_TICKS) |-> !cpu_clk_en && !presc_tick;
  endproperty
  a_por_hold: assert property (p_por_hold) // see RULE5
    else $error("cpu clock before 17 internal ticks");

  property p_por_step;
    $rose(por_done) |-> $past(por_cnt_reg) == 5'h10 && $past(int_rise);
  endproperty
  a_por_step: assert property (p_por_step) // see RULE5
    else $error("start count did not end on the 17th tick");

  property p_start_internal;
    !por_done |-> !cpu_clock_source_flag;
  endproperty
  a_start_internal: assert property (p_start_internal) // see RULE4
    else $error("cpu not on internal clock at start");

  property p_src_follow;
    $changed(cpu_clock_source_flag) |->
      cpu_clock_source_flag == $past(cpu_clock_select);
  endproperty
  a_src_follow: assert property (p_src_follow) // see RULE8
    else $error("source flag moved away from select");

  property p_int_osc_kept;
    strap_done_reg && !stoppable_reg && ce |=> int_osc_en;
  endproperty
  a_int_osc_kept: assert property (p_int_osc_kept) // see RULE2
    else $error("internal oscillator stopped while not stoppable");

  property p_hs_tick;
    por_done && cpu_clock_source_flag && hs_rise && !stop_mode
      |-> presc_tick;
  endproperty
  a_hs_tick: assert property (p_hs_tick) // see RULE3
    else $error("prescaler missed a high-speed tick");

  property p_stab_time_status_reg_clear;
    ce && (stop_mode || mstop_reg) |=> stab_time_status_reg == 5'h00;
  endproperty
  a_stab_time_status_reg_clear: assert property (p_stab_time_status_reg_clear) // see RULE15
    else $error("status not cleared");

  property p_stab_time_status_reg_order;
    stab_time_status_reg inside {5'h00, 5'h10, 5'h18, 5'h1c, 5'h1e, 5'h1f};
  endproperty
  a_stab_time_status_reg_order: assert property (p_stab_time_status_reg_order) // see RULE15
    else $error("status bits out of order");

  property p_stab_time_select_reg_legal;
    stab_time_select_reg inside {[CCSS_SEL11:CCSS_SEL16]};
  endproperty
  a_stab_time_select_reg_legal: assert property (p_stab_time_select_reg_legal) // see RULE14
    else $error("prohibited select code stored");

  property p_stop_wait;
    s_stop_release ##1 s_hs_wait |-> !cpu_clk_en;
  endproperty
  a_stop_wait: assert property (p_stop_wait) // see RULE11
    else $error("cpu clocked during stabilisation wait");

  property p_osc_up;
    $rose(strap_done_reg) |-> int_osc_en
      && (hs_osc_en == !($past(mstop_reg) || $past(stop_mode)));
  endproperty
  a_osc_up: assert property (p_osc_up) // see RULE1
    else $error("oscillators did not start after reset");
endmodule : ccss_clkgen

/* ccss_sync.sv */
// Purpose: constants for the cpu clock start and switch block, and the
//          pin synchroniser with rising-edge detect
// Assumes: oscillator outputs arrive as slow levels, well below pclk / 4
// Notes:   one package and one leaf module
package ccss_pkg;
  localparam int          CCSS_AW           = 8;
  localparam logic [7:0]  CCSS_MCM_OFS      = 8'h00;
  localparam logic [7:0]  CCSS_RCM_OFS      = 8'h04;
  localparam logic [7:0]  CCSS_MOC_OFS      = 8'h08;
  localparam logic [7:0]  CCSS_STAB_TIME_SELECT_REG_OFS     = 8'h0c;
  localparam logic [7:0]  CCSS_STAB_TIME_STATUS_REG_OFS     = 8'h10;
  // field positions
  localparam int          CCSS_SEL_BIT      = 0;
  localparam int          CCSS_SRC_BIT      = 1;
  localparam int          CCSS_RSTOP_BIT    = 0;
  localparam int          CCSS_MSTOP_BIT    = 7;
  // values after reset
  localparam logic [2:0]  CCSS_STAB_TIME_SELECT_REG_RST     = 3'h5;
  localparam logic [4:0]  CCSS_STAB_TIME_STATUS_REG_RST     = 5'h00;
  // nominal internal oscillator rate, kHz
  localparam int          CCSS_INT_FREQ_KHZ = 240;
  // internal oscillator ticks held off after reset release
  localparam logic [4:0]  CCSS_POR_TICKS    = 5'h11;
  // stabilisation thresholds in high-speed periods
  localparam logic [16:0] CCSS_T11          = 17'h00800;
  localparam logic [16:0] CCSS_T13          = 17'h02000;
  localparam logic [16:0] CCSS_T14          = 17'h04000;
  localparam logic [16:0] CCSS_T15          = 17'h08000;
  localparam logic [16:0] CCSS_T16          = 17'h10000;
  // legal select codes
  localparam logic [2:0]  CCSS_SEL11        = 3'h1;
  localparam logic [2:0]  CCSS_SEL13        = 3'h2;
  localparam logic [2:0]  CCSS_SEL14        = 3'h3;
  localparam logic [2:0]  CCSS_SEL15        = 3'h4;
  localparam logic [2:0]  CCSS_SEL16        = 3'h5;
endpackage : ccss_pkg

`timescale 1ns/1ps
module ccss_sync (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  // pin level and its edge
  input  wire logic d,
  output logic      rise
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic stable_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg     <= 1'b0;
      s2_reg     <= 1'b0;
      s3_reg     <= 1'b0;
      stable_reg <= 1'b0;
    end else if (ce) begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        stable_reg <= s3_reg;
      end
    end
  end

  // a rise counts once second and third agree high
  assign rise = ce && s2_reg && s3_reg && !stable_reg;
endmodule : ccss_sync

/* ccss_tb.sv */
// Purpose: self-checking bench for the cpu clock start and switch block
// Assumes: apb read data is taken at the completing edge
// Notes:   oscillator pins toggled slowly, 8 pclk per period
`timescale 1ns/1ps
`define CHK(g, e) chk(32'(g), 32'(e))
module testbench;
  import ccss_pkg::*;
  logic               pclk;
  logic               presetn;
  logic               ce;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [CCSS_AW-1:0] paddr;
  logic [31:0]        pwdata;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic               int_osc_in;
  logic               hs_osc_in;
  logic               int_osc_stoppable;
  logic               stop_mode;
  logic               int_osc_en;
  logic               hs_osc_en;
  logic               cpu_clk_en;
  logic               presc_tick;
  logic               cpu_clock_source_flag;
  logic [31:0]        rd;
  logic               err_seen;
  logic [2:0]         last_sel;
  int                 err_count;
  int                 compares;
  int                 cpu_cnt;
  int                 presc_cnt;
  int                 held;

  ccss_clkgen dut_u (
    .pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .int_osc_in(int_osc_in), .hs_osc_in(hs_osc_in),
    .int_osc_stoppable(int_osc_stoppable), .stop_mode(stop_mode),
    .int_osc_en(int_osc_en), .hs_osc_en(hs_osc_en),
    .cpu_clk_en(cpu_clk_en), .presc_tick(presc_tick),
    .cpu_clock_source_flag(cpu_clock_source_flag)
  );

  always #5 pclk = ~pclk;

  // tick counters
  always @(posedge pclk) begin
    if (cpu_clk_en === 1'b1) cpu_cnt++;
    if (presc_tick === 1'b1) presc_cnt++;
  end

  task finish_test;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk

  // one apb transfer, read data kept in rd
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    err_seen = pslverr;
    rd       = prdata;
    if (n >= 50) begin
      err_count++;
      finish_test();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // n slow rising edges on one oscillator pin
  task osc(input bit hs, input int n);
    repeat (n) begin
      @(posedge pclk);
      if (hs) hs_osc_in <= 1'b1;
      else int_osc_in <= 1'b1;
      repeat (4) @(posedge pclk);
      if (hs) hs_osc_in <= 1'b0;
      else int_osc_in <= 1'b0;
      repeat (3) @(posedge pclk);
    end
  endtask : osc

  task do_reset(input logic strap);
    @(posedge pclk);
    presetn           <= 1'b0;
    int_osc_stoppable <= strap;
    repeat (10) @(posedge pclk);
    `CHK(int_osc_en, 1'b0);
    `CHK(hs_osc_en, 1'b0);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    cpu_cnt   = 0;
    presc_cnt = 0;
  endtask : do_reset

  initial begin
    pclk = 0; presetn = 0; ce = 1; psel = 0; penable = 0; pwrite = 0;
    paddr = '0; pwdata = '0; int_osc_in = 0; hs_osc_in = 0;
    int_osc_stoppable = 1; stop_mode = 0;
    err_count = 0; compares = 0; cpu_cnt = 0; presc_cnt = 0;
    do_reset(1'b1);
    `CHK(int_osc_en, 1'b1);
    `CHK(hs_osc_en, 1'b1);
    // reset values and read-only bits
    apb(1, CCSS_MCM_OFS, 32'h2);
    apb(0, CCSS_MCM_OFS, 32'h0);
    `CHK(rd[1:0], 2'h0);
    apb(1, CCSS_STAB_TIME_STATUS_REG_OFS, 32'h1f);
    apb(0, CCSS_STAB_TIME_STATUS_REG_OFS, 32'h0);
    `CHK(rd[4:0], CCSS_STAB_TIME_STATUS_REG_RST);
    // start hold-off
    osc(0, 17);
    `CHK(cpu_cnt, 0);
    osc(0, 3);
    `CHK(cpu_cnt, 3);
    `CHK(presc_cnt != 0, 1'b1);
    // select codes, illegal ones ignored
    last_sel = CCSS_STAB_TIME_SELECT_REG_RST;
    apb(0, CCSS_STAB_TIME_SELECT_REG_OFS, 32'h0);
    `CHK(rd[2:0], last_sel);
    for (int c = 0; c < 8; c++) begin
      apb(1, CCSS_STAB_TIME_SELECT_REG_OFS, 32'(c));
      apb(0, CCSS_STAB_TIME_SELECT_REG_OFS, 32'h0);
      if (c >= 1 && c <= 5) last_sel = 3'(c);
      `CHK(rd[2:0], last_sel);
    end
    // unmapped address
    apb(0, 8'h20, 32'h0);
    `CHK(err_seen, 1'b1);
    `CHK(rd, 32'h0);
    // first stabilisation threshold
    osc(1, 2047);
    apb(0, CCSS_STAB_TIME_STATUS_REG_OFS, 32'h0);
    `CHK(rd[4:0], 5'h00);
    osc(1, 1);
    apb(0, CCSS_STAB_TIME_STATUS_REG_OFS, 32'h0);
    `CHK(rd[4:0], 5'h10);
    // switch cpu to high-speed clock
    apb(1, CCSS_MCM_OFS, 32'h1);
    osc(1, 2);
    `CHK(cpu_clock_source_flag, 1'b1);
    apb(0, CCSS_MCM_OFS, 32'h0);
    `CHK(rd[1:0], 2'h3);
    presc_cnt = 0;
    osc(1, 4);
    `CHK(presc_cnt, 4);
    osc(0, 4);
    `CHK(presc_cnt, 4);
    // stoppable internal oscillator, source flag 1
    apb(1, CCSS_RCM_OFS, 32'h1);
    repeat (2) @(posedge pclk);
    `CHK(int_osc_en, 1'b0);
    apb(1, CCSS_RCM_OFS, 32'h0);
    repeat (2) @(posedge pclk);
    `CHK(int_osc_en, 1'b1);
    // stop release on the high-speed clock, shortest wait
    apb(1, CCSS_STAB_TIME_SELECT_REG_OFS, 32'(CCSS_SEL11));
    stop_mode <= 1'b1;
    apb(0, CCSS_STAB_TIME_STATUS_REG_OFS, 32'h0);
    `CHK(rd[4:0], 5'h00);
    stop_mode <= 1'b0;
    held = cpu_cnt;
    osc(1, 2048);
    `CHK(cpu_cnt, held);
    osc(1, 1);
    `CHK(cpu_cnt, held + 1);
    apb(0, CCSS_STAB_TIME_STATUS_REG_OFS, 32'h0);
    `CHK(rd[4:0], 5'h10);
    // reset while on the high-speed clock, strap not stoppable
    do_reset(1'b0);
    apb(0, CCSS_MCM_OFS, 32'h0);
    `CHK(rd[1:0], 2'h0);
    `CHK(cpu_clock_source_flag, 1'b0);
    apb(1, CCSS_RCM_OFS, 32'h1);
    repeat (2) @(posedge pclk);
    `CHK(int_osc_en, 1'b1);
    // high-speed oscillator stop with flag 0
    apb(1, CCSS_MOC_OFS, 32'h80);
    repeat (2) @(posedge pclk);
    `CHK(hs_osc_en, 1'b0);
    apb(0, CCSS_STAB_TIME_STATUS_REG_OFS, 32'h0);
    `CHK(rd[4:0], 5'h00);
    apb(1, CCSS_MOC_OFS, 32'h0);
    repeat (2) @(posedge pclk);
    `CHK(hs_osc_en, 1'b1);
    // stop mode gates cpu ticks and high-speed oscillator
    osc(0, 18);
    stop_mode <= 1'b1;
    repeat (2) @(posedge pclk);
    `CHK(hs_osc_en, 1'b0);
    held = cpu_cnt;
    osc(0, 3);
    `CHK(cpu_cnt, held);
    stop_mode <= 1'b0;
    apb(0, CCSS_STAB_TIME_STATUS_REG_OFS, 32'h0);
    `CHK(rd[4:0], 5'h00);
    osc(0, 1);
    `CHK(cpu_cnt, held + 1);
    apb(1, CCSS_MCM_OFS, 32'h1);
    osc(1, 1);
    `CHK(cpu_clock_source_flag, 1'b1);
    finish_test();
  end
endmodule : testbench
